// *** src/chs_map.svh ***
`ifndef CHS_MAP_SVH
`define CHS_MAP_SVH

// 7-bit target address, direction bit follows
`define CHS_SLAVE_ADDR          7'h09

// command codes
`define CHS_CMD_OPTION0         8'h12
`define CHS_CMD_CHG_CURRENT     8'h14
`define CHS_CMD_MAX_VOLTAGE     8'h15
`define CHS_CMD_STATUS          8'h20
`define CHS_CMD_THROTTLE_STAT   8'h21
`define CHS_CMD_INPUT_LIMIT     8'h22
`define CHS_CMD_ADC_VIN_SYSTEM_POWER_RESULT    8'h23
`define CHS_CMD_ADC_IBAT        8'h24
`define CHS_CMD_OPTION1         8'h30
`define CHS_CMD_OPTION2         8'h31
`define CHS_CMD_OPTION3         8'h32
`define CHS_CMD_THROTTLE_OPT0   8'h33
`define CHS_CMD_THROTTLE_OPT1   8'h34
`define CHS_CMD_CONV_OPTION     8'h35
`define CHS_CMD_MAKER_ID        8'hFE
`define CHS_CMD_PART_ID         8'hFF

// field layouts
`define CHS_BATTERY_CHARGE_CURRENT_RESULT_LSB            6
`define CHS_BATTERY_CHARGE_CURRENT_RESULT_MSB            12
`define CHS_VMAX_LSB            4
`define CHS_VMAX_MSB            14
`define CHS_IIN_LSB             8
`define CHS_IIN_MSB             14

// reset values
`define CHS_RST_OPTION0         16'hE20E
`define CHS_RST_CHG_CURRENT     16'h0000
`define CHS_RST_MAX_VOLTAGE     16'h1060
`define CHS_RST_OTHER           16'h0000

// watchdog: 175 s at 25 MHz
`define CHS_WDOG_SECONDS        175
`define CHS_CLK_HZ              25000000

`endif

// *** src/chs_pkg.sv ***
package chs_pkg;

    typedef enum logic [2:0] {
        CHS_IDLE,
        CHS_ADDR,
        CHS_CMD,
        CHS_WLOW,
        CHS_WHIGH,
        CHS_RDATA,
        CHS_IGNORE
    } chs_state_e;

    typedef struct packed {
        logic        start;
        logic        stop;
        logic        rise;
        logic        fall;
        logic        sda;
    } chs_bus_ev_s;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] throttle_status;
        logic [15:0] input_limit;
        logic [15:0] adc_vin_system_power_result;
        logic [15:0] adc_ibat;
    } chs_ro_s;

    typedef struct packed {
        logic [15:0] option0;
        logic [15:0] chg_current;
        logic [15:0] max_voltage;
        logic [15:0] option1;
        logic [15:0] option2;
        logic [15:0] option3;
        logic [15:0] throttle_opt0;
        logic [15:0] throttle_opt1;
        logic [15:0] conv_option;
    } chs_rw_s;

endpackage

// *** src/chs_line_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module chs_line_sync
    import chs_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output chs_bus_ev_s      o_ev
);
    typedef struct packed {
        logic [1:0] scl_meta;
        logic [1:0] sda_meta;
        logic       scl_old;
        logic       sda_old;
    } chs_sync_s;

    chs_sync_s st_reg;
    chs_sync_s st_next;

    always_comb begin
        st_next          = st_reg;
        st_next.scl_meta = {st_reg.scl_meta[0], i_scl};
        st_next.sda_meta = {st_reg.sda_meta[0], i_sda};
        st_next.scl_old  = st_reg.scl_meta[1];
        st_next.sda_old  = st_reg.sda_meta[1];
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_old: 1'b1, sda_old: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // start/stop only while scl stays high across the sda edge
    always_comb begin
        o_ev.sda   = st_reg.sda_meta[1];
        o_ev.rise  = st_reg.scl_meta[1] & ~st_reg.scl_old;
        o_ev.fall  = ~st_reg.scl_meta[1] & st_reg.scl_old;
        o_ev.start = st_reg.scl_meta[1] & st_reg.scl_old & st_reg.sda_old & ~st_reg.sda_meta[1];
        o_ev.stop  = st_reg.scl_meta[1] & st_reg.scl_old & ~st_reg.sda_old & st_reg.sda_meta[1];
    end
endmodule // chs_line_sync
`default_nettype wire

// *** src/chs_smbus_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "chs_map.svh"

// What this block does
// - only word write and word read, register chosen by command byte
// - answer only to 7-bit address 0001001 plus direction bit
// - target only; never drives scl nor starts a transaction
// - two read-only identity words at commands FF and FE
// - maker identity read always returns the same fixed code
// - bus ignored until supply is above the lockout level
// - falling sda while scl high marks a new frame
// - rising sda while scl high frees the bus
// - sda changes only while scl low, apart from start and stop
// - bytes are eight bits msb first, sampled on scl rise
// - nine clocks per byte, receiver drives ninth-cycle acknowledge
// - write: address+w, command, low, high; all four acknowledged
// - read: address+w, command, restart, address+r, low acked, high nacked
// - acknowledge is sda low in ninth cycle, nack is sda high
// - charge current is 7 bits of 64 mA at command 14h
// - max charge voltage is 11 bits of 16 mV, fixed reset default 1060h
// - input limit in use is read-only 7 bits of 50 mA
// - word of system power and input voltage results, read-only
// - word of battery charge and discharge current results, read-only
// - writes to charge current or voltage restart the charge watchdog
module chs_smbus_slave
    import chs_pkg::*;
#(
    // 175 s of clock does not fit in 32 bits, hence the wide type
    parameter longint      WDOG_CYCLES = longint'(`CHS_WDOG_SECONDS) * `CHS_CLK_HZ,
    parameter logic [15:0] PART_ID  = 16'h1234, // arbitrary value
    parameter logic [15:0] MAKER_ID = 16'h00A5  // arbitrary value
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_supply_ok,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe,
    input  wire chs_ro_s     i_ro,
    output chs_rw_s          o_rw,
    output logic             o_wdog_expired
);

    // ************************************************************
    // pin conditioning
    // ************************************************************
    chs_bus_ev_s ev;
    logic [1:0]  supply_meta;

    chs_line_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .o_ev      (ev)
    );

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0]  supply_meta;
        chs_state_e  state;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic [7:0]  cmd;
        logic [7:0]  low_byte;
        logic [15:0] rdata;
        logic        ack_phase;
        logic        drive_low;
        logic        host_nack;
        chs_rw_s     rw;
        logic [32:0] wdog;
        logic        expired;
    } chs_state_s;

    chs_state_s st_reg;
    chs_state_s st_next;

    assign supply_meta = st_reg.supply_meta;

    function automatic logic [15:0] read_word(input logic [7:0] c, input chs_rw_s rw, input chs_ro_s ro);
        logic [15:0] w;
        w = 16'h0000;
        unique case (c)
            `CHS_CMD_OPTION0:       w = rw.option0;
            `CHS_CMD_CHG_CURRENT:   w = rw.chg_current;
            `CHS_CMD_MAX_VOLTAGE:   w = rw.max_voltage;
            `CHS_CMD_OPTION1:       w = rw.option1;
            `CHS_CMD_OPTION2:       w = rw.option2;
            `CHS_CMD_OPTION3:       w = rw.option3;
            `CHS_CMD_THROTTLE_OPT0: w = rw.throttle_opt0;
            `CHS_CMD_THROTTLE_OPT1: w = rw.throttle_opt1;
            `CHS_CMD_CONV_OPTION:   w = rw.conv_option;
            `CHS_CMD_STATUS:        w = ro.status;
            `CHS_CMD_THROTTLE_STAT: w = ro.throttle_status;
            `CHS_CMD_INPUT_LIMIT:   w = {1'b0, ro.input_limit[`CHS_IIN_MSB:`CHS_IIN_LSB], 8'h00};
            `CHS_CMD_ADC_VIN_SYSTEM_POWER_RESULT:  w = ro.adc_vin_system_power_result;
            `CHS_CMD_ADC_IBAT:      w = ro.adc_ibat;
            `CHS_CMD_MAKER_ID:      w = MAKER_ID;
            `CHS_CMD_PART_ID:       w = PART_ID;
            default:                w = 16'h0000;
        endcase
        return w;
    endfunction

    // ************************************************************
    // protocol engine
    // ************************************************************
    logic [7:0]  byte_in;
    logic        ready;
    logic [15:0] rword;

    always_comb begin
        st_next             = st_reg;
        st_next.supply_meta = {st_reg.supply_meta[0], i_supply_ok};
        ready               = supply_meta[1];
        byte_in             = {st_reg.shift[6:0], ev.sda};
        rword               = read_word(st_reg.cmd, st_reg.rw, i_ro);

        // watchdog counts down and holds at zero; mask expiry clears charge current
        if (st_reg.wdog != 33'h0) begin
            st_next.wdog = st_reg.wdog - 33'h1;
        end else if (!st_reg.expired) begin
            st_next.expired        = 1'b1;
            st_next.rw.chg_current = 16'h0000;
        end

        if (!ready) begin
            st_next.state     = CHS_IDLE;
            st_next.drive_low = 1'b0;
        end else if (ev.stop) begin
            st_next.state     = CHS_IDLE;
            st_next.drive_low = 1'b0;
        end else if (ev.start) begin
            st_next.state     = CHS_ADDR;
            st_next.bit_cnt   = 4'h0;
            st_next.ack_phase = 1'b0;
            st_next.drive_low = 1'b0;
        end else if (st_reg.state != CHS_IDLE && st_reg.state != CHS_IGNORE) begin
            if (ev.rise) begin
                if (!st_reg.ack_phase) begin
                    st_next.shift   = byte_in;
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                end else begin
                    st_next.host_nack = ev.sda;
                end
            end else if (ev.fall) begin
                st_next.drive_low = 1'b0;
                if (!st_reg.ack_phase && st_reg.bit_cnt == 4'h8) begin
                    // ninth clock: receiver acknowledges
                    st_next.ack_phase = 1'b1;
                    unique case (st_reg.state)
                        CHS_ADDR: begin
                            if (st_reg.shift[7:1] == `CHS_SLAVE_ADDR) begin
                                st_next.drive_low = 1'b1;
                            end else begin
                                st_next.state     = CHS_IGNORE;
                                st_next.ack_phase = 1'b0;
                            end
                        end
                        CHS_CMD, CHS_WLOW, CHS_WHIGH: begin
                            st_next.drive_low = 1'b1;
                        end
                        CHS_RDATA: begin
                            st_next.drive_low = 1'b0; // host acknowledges
                        end
                        default: begin
                            st_next.drive_low = 1'b0;
                        end
                    endcase
                end else if (st_reg.ack_phase) begin
                    st_next.ack_phase = 1'b0;
                    st_next.bit_cnt   = 4'h0;
                    unique case (st_reg.state)
                        CHS_ADDR: begin
                            if (st_reg.shift[0]) begin
                                st_next.state = CHS_RDATA;
                                st_next.rdata     = rword;
                                st_next.shift     = rword[7:0];
                                st_next.drive_low = ~rword[7];
                            end else begin
                                st_next.state = CHS_CMD;
                            end
                        end
                        CHS_CMD: begin
                            st_next.cmd   = st_reg.shift;
                            st_next.state = CHS_WLOW;
                        end
                        CHS_WLOW: begin
                            st_next.low_byte = st_reg.shift;
                            st_next.state    = CHS_WHIGH;
                        end
                        CHS_WHIGH: begin
                            st_next.state = CHS_IGNORE; // commit below
                            unique case (st_reg.cmd)
                                `CHS_CMD_OPTION0:       st_next.rw.option0 = {st_reg.shift, st_reg.low_byte};
                                `CHS_CMD_CHG_CURRENT: begin
                                    st_next.rw.chg_current = {3'h0, st_reg.shift[4:0], st_reg.low_byte[7:6], 6'h00};
                                    st_next.wdog    = 33'(WDOG_CYCLES);
                                    st_next.expired = 1'b0;
                                end
                                `CHS_CMD_MAX_VOLTAGE: begin
                                    st_next.rw.max_voltage = {1'b0, st_reg.shift[6:0], st_reg.low_byte[7:4], 4'h0};
                                    st_next.wdog    = 33'(WDOG_CYCLES);
                                    st_next.expired = 1'b0;
                                end
                                `CHS_CMD_OPTION1:       st_next.rw.option1       = {st_reg.shift, st_reg.low_byte};
                                `CHS_CMD_OPTION2:       st_next.rw.option2       = {st_reg.shift, st_reg.low_byte};
                                `CHS_CMD_OPTION3:       st_next.rw.option3       = {st_reg.shift, st_reg.low_byte};
                                `CHS_CMD_THROTTLE_OPT0: st_next.rw.throttle_opt0 = {st_reg.shift, st_reg.low_byte};
                                `CHS_CMD_THROTTLE_OPT1: st_next.rw.throttle_opt1 = {st_reg.shift, st_reg.low_byte};
                                `CHS_CMD_CONV_OPTION:   st_next.rw.conv_option   = {st_reg.shift, st_reg.low_byte};
                                // nothing written; keeps an expiry clear of the same cycle
                                default:                st_next.state = CHS_IGNORE;
                            endcase
                        end
                        CHS_RDATA: begin
                            if (st_reg.host_nack) begin
                                st_next.state = CHS_IGNORE; // host done
                            end else begin
                                st_next.shift     = st_reg.rdata[15:8];
                                st_next.rdata     = {st_reg.rdata[15:8], 8'h00};
                                st_next.drive_low = ~st_reg.rdata[15];
                            end
                        end
                        default: begin
                            st_next.state = CHS_IGNORE;
                        end
                    endcase
                end else if (st_reg.state == CHS_RDATA && st_reg.bit_cnt != 4'h8) begin
                    // next bit out on scl low
                    st_next.drive_low = ~st_reg.shift[7];
                end
                if (st_reg.state == CHS_RDATA && !st_reg.ack_phase && st_reg.bit_cnt != 4'h8) begin
                    st_next.drive_low = ~st_reg.shift[7];
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg                  <= '0;
            st_reg.state            <= CHS_IDLE;
            st_reg.rw.option0       <= `CHS_RST_OPTION0;
            st_reg.rw.chg_current   <= `CHS_RST_CHG_CURRENT;
            st_reg.rw.max_voltage   <= `CHS_RST_MAX_VOLTAGE;
            st_reg.wdog             <= 33'(WDOG_CYCLES);
        end else begin
            st_reg <= st_next;
        end
    end

    // open drain: only ever pull low, never touch scl
    assign o_sda          = 1'b0;
    assign o_sda_oe       = st_reg.drive_low;
    assign o_rw           = st_reg.rw;
    assign o_wdog_expired = st_reg.expired;

endmodule // chs_smbus_slave
`default_nettype wire

// *** bench/chs_smbus_slave_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module chs_smbus_slave_sva
    import chs_pkg::*;
#(
    parameter longint WDOG_CYCLES = 1000
) (
    input  wire logic    i_sys_clk,
    input  wire logic    i_resetn,
    input  wire logic    i_supply_ok,
    input  wire logic    i_scl,
    input  wire logic    i_sda,
    input  wire logic    o_sda,
    input  wire logic    o_sda_oe,
    input  wire chs_ro_s i_ro,
    input  wire chs_rw_s o_rw,
    input  wire logic    o_wdog_expired
);
    // ****************************************
    // checks at the ports
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    int up_cnt_reg;
    // saturating age since reset; expiry cannot come earlier
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            up_cnt_reg <= 0;
        end else if (up_cnt_reg < WDOG_CYCLES) begin
            up_cnt_reg <= up_cnt_reg + 1;
        end
    end
    a_never_drive_high: assert property (o_sda == 1'b0) else $error("sda driven high");
    a_lockout_quiet: assert property (!i_supply_ok [*4] |-> !o_sda_oe) else $error("drive under lockout");
    a_oe_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("sda taken while scl high");
    a_cc_field: assert property ((o_rw.chg_current & ~16'h1FC0) == 16'h0) else $error("charge current bits");
    a_vmax_field: assert property ((o_rw.max_voltage & ~16'h7FF0) == 16'h0) else $error("voltage bits");
    a_reset_vals: assert property ($rose(i_resetn) |->
        o_rw.option0 == 16'hE20E && o_rw.max_voltage == 16'h1060) else $error("reset values");
    a_write_powered: assert property ($changed(o_rw.option0) |-> $past(i_supply_ok, 3))
        else $error("write under lockout");
    a_wdog_zero: assert property ($rose(o_wdog_expired) |-> ##[0:2] o_rw.chg_current == 16'h0)
        else $error("expiry kept current");
    a_wdog_early: assert property (o_wdog_expired |-> up_cnt_reg >= WDOG_CYCLES - 4)
        else $error("watchdog early");
    cover property ($rose(o_sda_oe));
    cover property ($rose(o_wdog_expired));
    cover property ($fell(o_wdog_expired));
endmodule // chs_smbus_slave_sva

bind chs_smbus_slave chs_smbus_slave_sva #(.WDOG_CYCLES(WDOG_CYCLES)) u_sva (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_supply_ok(i_supply_ok), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .i_ro(i_ro), .o_rw(o_rw), .o_wdog_expired(o_wdog_expired));
`default_nettype wire

// *** bench/chs_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module chs_host_model (
    input  wire logic i_sda_line,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    // ****************************************
    // bus master, open drain on both lines
    // ****************************************
    // scl stands high between frames
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // long low phase leaves the target time to turn sda round
    task automatic bit_io(input logic b, output logic r);
        #40 o_sda_low = ~b;
        #160 o_scl_low = 1'b0;
        #110 r = i_sda_line;
        #10 o_scl_low = 1'b1;
    endtask
    task automatic start();
        #40 o_sda_low = 1'b0;
        #200 o_scl_low = 1'b0;
        #120 o_sda_low = 1'b1;
        #120 o_scl_low = 1'b1;
    endtask
    task automatic stop();
        #40 o_sda_low = 1'b1;
        #120 o_scl_low = 1'b0;
        #120 o_sda_low = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input int n,
                      output logic [3:0] acks);
        logic [7:0] rx;
        acks = 4'hF;
        start();
        byte_io({a, 1'b0}, 1'b1, rx, acks[3]);
        byte_io(c, 1'b1, rx, acks[2]);
        if (n > 0) byte_io(d[7:0], 1'b1, rx, acks[1]);
        if (n > 1) byte_io(d[15:8], 1'b1, rx, acks[0]);
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d, output logic [2:0] acks);
        logic [7:0] rx;
        start();
        byte_io({a, 1'b0}, 1'b1, rx, acks[2]);
        byte_io(c, 1'b1, rx, acks[1]);
        start();
        byte_io({a, 1'b1}, 1'b1, rx, acks[0]);
        byte_io(8'hFF, 1'b0, d[7:0], rx[0]);
        byte_io(8'hFF, 1'b1, d[15:8], rx[0]);
        stop();
    endtask
endmodule // chs_host_model
`default_nettype wire

// *** bench/chs_smbus_slave_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "chs_map.svh"
module chs_smbus_slave_tb;
    import chs_pkg::*;
    localparam int          WDOG  = 3000;
    localparam logic [15:0] MAKER = 16'h5A3C; // arbitrary value
    localparam logic [15:0] PART  = 16'hC3A5; // arbitrary value
    typedef struct packed {logic [7:0] cmd; logic [15:0] wdat; logic [15:0] rexp;} chs_row_s;
    logic       clk, resetn, supply_ok, scl_low, sda_low, sda_out, sda_oe, wdog;
    logic [3:0] acks4;
    logic [2:0] acks3;
    logic [15:0] rdat;
    chs_rw_s    rw;
    chs_ro_s    ro;
    int         n_mismatch, samples_checked;
    wire logic  scl = !scl_low;
    wire logic  sda = !(sda_low || (sda_oe && !sda_out));
    chs_row_s rows [17] = '{'{8'h12, 16'hA5A5, 16'hA5A5}, '{8'h14, 16'hFFFF, 16'h1FC0},
        '{8'h15, 16'hFFFF, 16'h7FF0}, '{8'h30, 16'h1234, 16'h1234}, '{8'h31, 16'h5678, 16'h5678},
        '{8'h32, 16'h9ABC, 16'h9ABC}, '{8'h33, 16'hDEF0, 16'hDEF0}, '{8'h34, 16'h0F0F, 16'h0F0F},
        '{8'h35, 16'hF0F0, 16'hF0F0}, '{8'h20, 16'hFFFF, 16'h1111}, '{8'h21, 16'hFFFF, 16'h2222},
        '{8'h22, 16'h0000, 16'h7F00}, '{8'h23, 16'h0000, 16'h4444}, '{8'h24, 16'h0000, 16'h5555},
        '{8'hFE, 16'hFFFF, MAKER}, '{8'hFF, 16'h0000, PART}, '{8'h50, 16'hFFFF, 16'h0000}};

    chs_smbus_slave #(.WDOG_CYCLES(WDOG), .PART_ID(PART), .MAKER_ID(MAKER)) uut (
        .i_sys_clk(clk), .i_resetn(resetn), .i_supply_ok(supply_ok), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_out), .o_sda_oe(sda_oe), .i_ro(ro), .o_rw(rw), .o_wdog_expired(wdog));
    chs_host_model host (.i_sda_line(sda), .o_scl_low(scl_low), .o_sda_low(sda_low));

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        supply_ok = 1'b1;
        ro = {16'h1111, 16'h2222, 16'hFFFF, 16'h4444, 16'h5555};
        n_mismatch = 0;
        samples_checked = 0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        check(rw === {16'hE20E, 16'h0000, 16'h1060, 96'h0}, "reset values");
        foreach (rows[i]) begin
            host.wr(`CHS_SLAVE_ADDR, rows[i].cmd, rows[i].wdat, 2, acks4);
            if (rows[i].cmd != 8'h50) check(acks4 === 4'h0, "write ack");
            host.rd(`CHS_SLAVE_ADDR, rows[i].cmd, rdat, acks3);
            check(acks3 === 3'h0, "read ack");
            check(rdat === rows[i].rexp, "read data");
        end
        // foreign address is never acknowledged
        host.wr(7'h0A, 8'h30, 16'h0000, 2, acks4);
        check(acks4 === 4'hF, "foreign address acked");
        check(rw.option1 === 16'h1234, "foreign write landed");
        // stop after the low byte
        host.wr(`CHS_SLAVE_ADDR, 8'h31, 16'h0000, 1, acks4);
        check(rw.option2 === 16'h5678, "half word committed");
        @(negedge clk);
        supply_ok = 1'b0;
        repeat (4) @(negedge clk);
        host.wr(`CHS_SLAVE_ADDR, 8'h32, 16'h0000, 2, acks4);
        check(acks4 === 4'hF, "acked under lockout");
        check(rw.option3 === 16'h9ABC, "write under lockout");
        @(negedge clk);
        supply_ok = 1'b1;
        repeat (4) @(negedge clk);
        host.wr(`CHS_SLAVE_ADDR, 8'h14, 16'h0140, 2, acks4);
        check(wdog === 1'b0, "watchdog not restarted");
        check(rw.chg_current === 16'h0140, "charge current");
        repeat (WDOG + 100) @(negedge clk);
        check(wdog === 1'b1, "watchdog not expired");
        check(rw.chg_current === 16'h0000, "current kept on expiry");
        host.wr(`CHS_SLAVE_ADDR, 8'h15, 16'h1060, 2, acks4);
        check(wdog === 1'b0, "voltage write did not resume");
        // mid-run reset with the bus idle
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        check(rw === {16'hE20E, 16'h0000, 16'h1060, 96'h0} && wdog === 1'b0, "mid-run reset");
        host.rd(`CHS_SLAVE_ADDR, 8'h12, rdat, acks3);
        check(acks3 === 3'h0 && rdat === 16'hE20E, "read after reset");
        stop_test();
    end
endmodule // chs_smbus_slave_tb
`default_nettype wire
